/* hw/druc_uart.v */
// Descriptor ring UART channel with APB registers and internal buffers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "druc_defines.vh"
module druc_uart #(
  parameter NBD = 4,
  parameter BUFW = 4
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial line
  input wire rxd,
  output reg txd,
  // Buffer completion requests
  output reg tx_event,
  output reg rx_event
);
  localparam RX_HUNT = 3'b001;
  localparam RX_BITS = 3'b010;
  localparam RX_BRK = 3'b100;

  // Data bits in a character from the length field
  function [3:0] dlen_f;
    input [3:0] cl;
    input pe;
    input s;
    begin
      dlen_f = cl - {3'h0, pe} - {3'h0, s} - 4'h1;
    end
  endfunction

  // Line frame, bit 0 first: start, data, parity, stops
  function [15:0] tx_frame;
    input [15:0] d;
    input [3:0] cl;
    input pe;
    input pmode;
    input s;
    reg [3:0] dl;
    reg [15:0] m;
    reg [15:0] f;
    reg par;
    begin
      dl = dlen_f(cl, pe, s);
      m = ~(16'hFFFF << dl);
      par = (^(d & m)) ^ ~pmode;
      f = (16'hFFFF << (dl + 4'h1)) | ((d & m) << 1);
      if (pe)
        f[dl + 4'h1] = par;
      tx_frame = f;
    end
  endfunction

  // Right-align a frame shifted in from the top
  function [15:0] rx_align;
    input [15:0] sh;
    input [3:0] cl;
    reg [31:0] t;
    begin
      t = {16'h0000, sh} >> (4'hF - cl);
      rx_align = t[15:0];
    end
  endfunction

  // Buffer word index of character k of descriptor b
  function [3:0] idx_f;
    input [1:0] b;
    input [1:0] k;
    integer n;
    begin
      n = b * BUFW + k;
      idx_f = n[3:0];
    end
  endfunction

  // Ring successor of a descriptor pointer
  function [1:0] next_ptr;
    input [1:0] p;
    input wrap;
    integer n;
    begin
      n = p + 1;
      if (wrap || n >= NBD)
        next_ptr = 2'h0;
      else
        next_ptr = n[1:0];
    end
  endfunction

  integer i;
  integer j;
  reg [15:0] mode;
  reg [15:0] idle_limit;
  reg [15:0] break_repeat_count;
  reg [15:0] baud_div;
  reg [15:0] div_cnt;
  reg bit_tick;
  reg [31:0] tx_bd [0:NBD-1];
  reg [31:0] rx_bd [0:NBD-1];
  reg [15:0] tx_mem [0:NBD*BUFW-1];
  reg [15:0] rx_mem [0:NBD*BUFW-1];
  reg [1:0] tx_descriptor_pointer;
  reg [1:0] tx_idx;
  reg [3:0] tx_bit;
  reg [15:0] tx_shift;
  reg tx_run;
  reg [15:0] brk_left;
  reg need_idle;
  reg pre_done;
  reg [2:0] rx_state;
  reg [15:0] rx_cnt;
  reg [3:0] rx_bit;
  reg [15:0] rx_shift;
  reg [3:0] idle_bits;
  reg [15:0] brk_len;
  reg [1:0] rx_ptr;
  reg [1:0] rx_k;
  reg rx_open;
  reg [15:0] idle_countdown;
  reg [15:0] last_break_length;
  reg [15:0] break_event_count;
  reg [31:0] rd_val;
  reg addr_ok;

  // Mode fields
  wire ren = mode[`MODE_REN];
  wire tx_enable_bit = mode[`MODE_TEN];
  wire pen = mode[`MODE_PEN];
  wire pm = mode[`MODE_PM];
  wire sl = mode[`MODE_SL];
  wire [3:0] char_length_field = mode[`MODE_CHAR_LENGTH_FIELD_MSB:`MODE_CHAR_LENGTH_FIELD_LSB];
  wire [3:0] dlen = dlen_f(char_length_field, pen, sl);

  // APB decode
  wire [3:0] region = paddr[11:8];
  wire [7:0] roff = paddr[7:0];
  wire [3:0] widx = paddr[5:2];
  wire apb_wr = psel & penable & pready & pwrite & ~pslverr;
  wire reg_wr = apb_wr & (region == `RGN_REGS);
  wire cmd_wr = reg_wr & (roff == `REG_CMD);
  wire [3:0] cmd_code = pwdata[3:0];
  wire init_tx = cmd_wr & ((cmd_code == `CMD_INIT_TX) |
                 (cmd_code == `CMD_INIT_BOTH));
  wire init_rx = cmd_wr & ((cmd_code == `CMD_INIT_RX) |
                 (cmd_code == `CMD_INIT_BOTH));
  wire stop_cmd = cmd_wr & (cmd_code == `CMD_STOP_TX);
  wire restart_cmd = cmd_wr & (cmd_code == `CMD_RESTART_TX);
  wire close_cmd = cmd_wr & (cmd_code == `CMD_CLOSE_RX);

  // Current transmit descriptor and character
  wire [31:0] cur_tbd = tx_bd[tx_descriptor_pointer];
  wire [3:0] cur_tlen = cur_tbd[`BD_LEN_MSB:`BD_LEN_LSB];
  wire [15:0] cur_tchar = tx_mem[idx_f(tx_descriptor_pointer, tx_idx)];
  wire tx_last = ({2'h0, tx_idx} + 4'h1) >= cur_tlen;
  wire tx_have = tx_run & cur_tbd[`BD_RDY] & (cur_tlen != 4'h0);

  // Receive character evaluation at the last sample
  wire rx_samp = (rx_state == RX_BITS) & (rx_cnt == 16'h0);
  wire rx_done = rx_samp & (rx_bit == char_length_field) & ren;
  wire [15:0] rx_frame = rx_align({rxd, rx_shift[15:1]}, char_length_field);
  wire [15:0] rx_data = (rx_frame >> 1) & ~(16'hFFFF << dlen);
  wire stop_ok = rx_frame[dlen + {3'h0, pen} + 4'h1];
  wire is_break = rx_done & (rx_frame == 16'h0000);
  wire [31:0] cur_rbd = rx_bd[rx_ptr];
  wire rx_store = rx_done & ~is_break &
                  (rx_open | cur_rbd[`BD_RDY]);
  wire [1:0] rx_kb = rx_open ? rx_k : 2'h0;
  wire [3:0] k_after = {2'h0, rx_kb} + 4'h1;
  wire idle_char = (rx_state == RX_HUNT) & ren & rxd &
                   (rx_cnt == 16'h0) & (idle_bits == char_length_field);
  wire close_full = rx_store & (k_after >= BUFW);
  wire close_frm = rx_store & ~stop_ok;
  wire close_brk = is_break & rx_open;
  wire close_idle = idle_char & rx_open & (idle_limit != 16'h0) &
                    (idle_countdown == 16'h0001);
  wire close_now = close_full | close_frm | close_brk | close_idle |
                   (close_cmd & rx_open);
  wire [3:0] close_len = rx_store ? k_after : {2'h0, rx_k};

  // Bit-rate divider: one-cycle tick every baud_div + 1 cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      bit_tick <= 1'b0;
    end else if (div_cnt == 16'h0000) begin
      div_cnt <= baud_div;
      bit_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
      bit_tick <= 1'b0;
    end
  end

  // Read mux and address check
  always @* begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b0;
    case (region)
      `RGN_REGS: begin
        addr_ok = 1'b1;
        case (roff)
          `REG_MODE: rd_val = {16'h0000, mode};
          `REG_CMD: rd_val = 32'h0000_0000;
          `REG_IDLE_LIMIT: rd_val = {16'h0000, idle_limit};
          `REG_IDLE_COUNT: rd_val = {16'h0000, idle_countdown};
          `REG_BRK_LEN: rd_val = {16'h0000, last_break_length};
          `REG_BRK_EVT: rd_val = {16'h0000, break_event_count};
          `REG_BRK_REP: rd_val = {16'h0000, break_repeat_count};
          `REG_BAUD: rd_val = {16'h0000, baud_div};
          `REG_STATUS: rd_val = {24'h000000, tx_run, rx_open, rx_ptr,
                                 2'h0, tx_descriptor_pointer};
          default: addr_ok = 1'b0;
        endcase
      end
      `RGN_TXBD: begin
        addr_ok = (roff[7:6] == 2'h0) && (widx < NBD);
        rd_val = tx_bd[widx[1:0]];
      end
      `RGN_RXBD: begin
        addr_ok = (roff[7:6] == 2'h0) && (widx < NBD);
        rd_val = rx_bd[widx[1:0]];
      end
      `RGN_TXMEM: begin
        addr_ok = (roff[7:6] == 2'h0) && (widx < NBD * BUFW);
        rd_val = {16'h0000, tx_mem[widx]};
      end
      `RGN_RXMEM: begin
        addr_ok = (roff[7:6] == 2'h0) && (widx < NBD * BUFW);
        rd_val = {16'h0000, rx_mem[widx]};
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer: data and ready are registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= addr_ok ? rd_val : 32'h0000_0000;
      pready <= 1'b1;
      pslverr <= ~addr_ok;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MODE_RST;
      idle_limit <= 16'h0000;
      break_repeat_count <= 16'h0000;
      baud_div <= `BAUD_RST;
    end else begin
      if (reg_wr && roff == `REG_MODE)
        mode <= pwdata[15:0];
      if (reg_wr && roff == `REG_IDLE_LIMIT)
        idle_limit <= pwdata[15:0];
      if (reg_wr && roff == `REG_BRK_REP)
        break_repeat_count <= pwdata[15:0];
      if (reg_wr && roff == `REG_BAUD)
        baud_div <= pwdata[15:0];
      if (init_tx)
        break_repeat_count <= 16'h0000;
      if (init_rx)
        idle_limit <= 16'h0000;
    end
  end

  // Buffer memories: software fills transmit data, receiver stores chars
  always @(posedge pclk) begin
    if (apb_wr && region == `RGN_TXMEM)
      tx_mem[widx] <= pwdata[15:0];
    if (rx_store)
      rx_mem[idx_f(rx_ptr, rx_kb)] <= rx_data;
    else if (apb_wr && region == `RGN_RXMEM)
      rx_mem[widx] <= pwdata[15:0];
  end

  // Transmitter: character slots on the line, chosen at each boundary
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NBD; i = i + 1)
        tx_bd[i] <= 32'h0000_0000;
      tx_descriptor_pointer <= 2'h0;
      tx_idx <= 2'h0;
      tx_bit <= 4'h0;
      tx_shift <= 16'hFFFF;
      tx_run <= 1'b1;
      brk_left <= 16'h0000;
      need_idle <= 1'b0;
      pre_done <= 1'b0;
      txd <= 1'b1;
      tx_event <= 1'b0;
    end else begin
      tx_event <= 1'b0;
      if (!tx_enable_bit) begin
        // Disabled: line high, next tick opens a new slot at once
        txd <= 1'b1;
        tx_bit <= 4'hF;
        tx_shift <= 16'hFFFF;
      end else if (bit_tick && tx_bit < char_length_field) begin
        tx_bit <= tx_bit + 4'h1;
        txd <= tx_shift[1];
        tx_shift <= {1'b1, tx_shift[15:1]};
      end else if (bit_tick) begin
        // Character boundary: the descriptor is polled here
        tx_bit <= 4'h0;
        if (brk_left != 16'h0000) begin
          txd <= 1'b0;
          tx_shift <= 16'h0000;
          brk_left <= brk_left - 16'h0001;
        end else if (need_idle) begin
          txd <= 1'b1;
          tx_shift <= 16'hFFFF;
          need_idle <= 1'b0;
        end else if (tx_have && cur_tbd[`BD_PRE] && !pre_done) begin
          txd <= 1'b1;
          tx_shift <= 16'hFFFF;
          pre_done <= 1'b1;
        end else if (tx_have) begin
          txd <= 1'b0;
          tx_shift <= tx_frame(cur_tchar, char_length_field, pen, pm, sl);
          pre_done <= 1'b1;
          if (tx_last) begin
            // Buffer done; the next one is polled at the next boundary
            if (!cur_tbd[`BD_CM])
              tx_bd[tx_descriptor_pointer][`BD_RDY] <= 1'b0;
            tx_event <= cur_tbd[`BD_INT];
            tx_descriptor_pointer <= next_ptr(tx_descriptor_pointer,
                                              cur_tbd[`BD_WRAP]);
            tx_idx <= 2'h0;
            pre_done <= 1'b0;
          end else begin
            tx_idx <= tx_idx + 2'h1;
          end
        end else begin
          txd <= 1'b1;
          tx_shift <= 16'hFFFF;
        end
      end
      if (apb_wr && region == `RGN_TXBD)
        tx_bd[widx[1:0]] <= pwdata;
      // Commands override pointer and state updates of the same cycle; the slot already chosen still goes out
      if (init_tx) begin
        tx_descriptor_pointer <= 2'h0;
        tx_idx <= 2'h0;
        tx_run <= 1'b1;
        brk_left <= 16'h0000;
        need_idle <= 1'b0;
        pre_done <= 1'b0;
      end else if (stop_cmd) begin
        tx_run <= 1'b0;
        tx_idx <= 2'h0;
        pre_done <= 1'b0;
        brk_left <= break_repeat_count;
        need_idle <= 1'b1;
      end else if (restart_cmd) begin
        tx_run <= 1'b1;
      end
    end
  end

  // Receiver: hunt, sample mid-bit, break length and idle counting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < NBD; j = j + 1)
        rx_bd[j] <= 32'h0000_0000;
      rx_state <= RX_HUNT;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_shift <= 16'h0000;
      idle_bits <= 4'h0;
      brk_len <= 16'h0000;
      rx_ptr <= 2'h0;
      rx_k <= 2'h0;
      rx_open <= 1'b0;
      idle_countdown <= 16'h0000;
      last_break_length <= 16'h0000;
      break_event_count <= 16'h0000;
      rx_event <= 1'b0;
    end else begin
      rx_event <= 1'b0;
      if (!ren) begin
        rx_state <= RX_HUNT;
        rx_cnt <= baud_div;
        idle_bits <= 4'h0;
      end else begin
        case (rx_state)
          RX_HUNT: begin
            if (!rxd) begin
              rx_state <= RX_BITS;
              rx_cnt <= {1'b0, baud_div[15:1]};
              rx_bit <= 4'h0;
              idle_bits <= 4'h0;
            end else if (rx_cnt == 16'h0000) begin
              rx_cnt <= baud_div;
              idle_bits <= idle_char ? 4'h0 : idle_bits + 4'h1;
            end else begin
              rx_cnt <= rx_cnt - 16'h0001;
            end
          end
          RX_BITS: begin
            if (rx_cnt != 16'h0000) begin
              rx_cnt <= rx_cnt - 16'h0001;
            end else begin
              rx_cnt <= baud_div;
              rx_shift <= {rxd, rx_shift[15:1]};
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit == 4'h0 && rxd) begin
                rx_state <= RX_HUNT;
              end else if (rx_done) begin
                rx_state <= is_break ? RX_BRK : RX_HUNT;
                brk_len <= {12'h000, char_length_field} + 16'h0001;
              end
            end
          end
          RX_BRK: begin
            if (rx_cnt != 16'h0000) begin
              rx_cnt <= rx_cnt - 16'h0001;
            end else if (rxd) begin
              rx_cnt <= baud_div;
              last_break_length <= brk_len;
              rx_state <= RX_HUNT;
            end else begin
              rx_cnt <= baud_div;
              brk_len <= brk_len + 16'h0001;
            end
          end
          default: rx_state <= RX_HUNT;
        endcase
      end
      if (is_break)
        break_event_count <= break_event_count + 16'h0001;
      // Idle down-counter reloads on data and steps on idle characters
      if (rx_store)
        idle_countdown <= idle_limit;
      else if (idle_char && rx_open && idle_countdown != 16'h0000)
        idle_countdown <= idle_countdown - 16'h0001;
      if (apb_wr && region == `RGN_RXBD)
        rx_bd[widx[1:0]] <= pwdata;
      // Buffer open, fill and close
      if (close_now) begin
        rx_bd[rx_ptr][`BD_RDY] <= cur_rbd[`BD_CM];
        rx_bd[rx_ptr][`BD_LEN_MSB:`BD_LEN_LSB] <= close_len;
        rx_bd[rx_ptr][`BD_BR] <= close_brk;
        rx_bd[rx_ptr][`BD_FR] <= close_frm;
        rx_bd[rx_ptr][`BD_ID] <= close_idle;
        rx_event <= cur_rbd[`BD_INT];
        rx_ptr <= next_ptr(rx_ptr, cur_rbd[`BD_WRAP]);
        rx_open <= 1'b0;
        rx_k <= 2'h0;
      end else if (rx_store) begin
        rx_open <= 1'b1;
        rx_k <= k_after[1:0];
      end
      if (init_rx) begin
        rx_ptr <= 2'h0;
        rx_open <= 1'b0;
        rx_k <= 2'h0;
        rx_state <= RX_HUNT;
        idle_countdown <= 16'h0000;
        last_break_length <= 16'h0000;
        break_event_count <= 16'h0000;
      end
    end
  end
endmodule

/* shared/druc_defines.vh */
// Register map, field layout and command codes of the descriptor ring UART
//
// Overview of operation
// - An idle limit of zero never closes a receive buffer on idles.
// - An idle character lasts start, data, optional parity and stop bits.
// - The running idle count lives in an internal down-counter.
// - After a break, its length in bit times is stored, within one character.
// - The break event counter steps once per break, however long it lasts.
// - Stop-transmit sends break repeat count all-zero characters, possibly none.
// - An enabled transmitter sends idles, polls at once, then every character.
// - A finished transmit buffer clears ready and requests an event if asked.
// - A ready next buffer follows without gap, otherwise idles are sent.
// - Continuous transmit descriptors keep ready set and are sent again.
// - An enabled receiver hunts, then checks the descriptor is empty, then stores.
// - Full buffer or idle timeout clears empty and requests an event if asked.
// - Overflowing data moves on to the next empty descriptor.
// - Continuous receive descriptors keep empty set and are overwritten.
// - Stop-transmit aborts the message, ends the character, keeps the pointer.
// - Restart-transmit resumes at the current transmit descriptor pointer.
// - Transmit initialise returns transmit parameters to reset state.
// - Receive initialise returns receive parameters to reset state.
// - Close-receive closes the open buffer; without reception it does nothing.
// - A break character is all zeros over the full character length.
// - After breaks, at least one idle character precedes any data.
// - A preamble flag sends one character of ones before the buffer.
// - Character length field holds total bits per character minus one.
// - All-ones characters count as idles; a data character resets the count.
// - An all-zero character with framing error is a break.
`ifndef DRUC_DEFINES_VH
`define DRUC_DEFINES_VH
// Address regions, selected by paddr[11:8]
`define RGN_REGS 4'h0
`define RGN_TXBD 4'h1
`define RGN_RXBD 4'h2
`define RGN_TXMEM 4'h3
`define RGN_RXMEM 4'h4
// Register offsets inside the register region
`define REG_MODE 8'h00
`define REG_CMD 8'h04
`define REG_IDLE_LIMIT 8'h08
`define REG_IDLE_COUNT 8'h0C
`define REG_BRK_LEN 8'h10
`define REG_BRK_EVT 8'h14
`define REG_BRK_REP 8'h18
`define REG_BAUD 8'h1C
`define REG_STATUS 8'h20
// Mode register fields
`define MODE_REN 0
`define MODE_TEN 1
`define MODE_PEN 2
`define MODE_PM 3
`define MODE_SL 4
`define MODE_CHAR_LENGTH_FIELD_LSB 8
`define MODE_CHAR_LENGTH_FIELD_MSB 11
`define MODE_RST 16'h0000
`define BAUD_RST 16'h0015
// Command codes
`define CMD_STOP_TX 4'h1
`define CMD_RESTART_TX 4'h2
`define CMD_INIT_TX 4'h3
`define CMD_INIT_RX 4'h4
`define CMD_INIT_BOTH 4'h5
`define CMD_CLOSE_RX 4'h6
// Descriptor word fields
`define BD_RDY 15
`define BD_WRAP 13
`define BD_INT 12
`define BD_CM 9
`define BD_PRE 8
`define BD_ID 8
`define BD_BR 5
`define BD_FR 4
`define BD_LEN_LSB 16
`define BD_LEN_MSB 19
`endif

/* testbench/druc_line_partner.sv */
// Remote UART on the serial line: drives rxd, decodes txd
`timescale 1ns/1ps
module druc_line_partner #(
  parameter BIT = 4,
  parameter NB = 10
) (
  // Serial line
  input wire pclk,
  input wire txd,
  output reg rxd
);
  reg [15:0] got = 16'h0;
  reg [15:0] fr;
  integer n_got = 0;
  integer span = 0;
  integer low_max = 0;
  integer low_t = 0;
  integer t = 0;
  integer t_last = 0;
  integer i;
  initial rxd = 1'b1;
  // Send n raw line bits LSB first; caller ends on a high bit
  task send(input [31:0] bits, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k++) begin
        rxd <= bits[k];
        repeat (BIT) @(posedge pclk);
      end
    end
  endtask
  // Cycle count and longest low run on txd
  always @(posedge pclk) begin
    t <= t + 1;
    low_t <= txd ? 0 : low_t + 1;
    if (!txd && low_t + 1 > low_max) low_max <= low_t + 1;
  end
  // Frame decoder: mid-bit samples, valid only with a high stop bit
  initial forever begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge pclk);
    span = t - t_last;
    t_last = t;
    for (i = 0; i < NB; i++) begin
      fr[i] = txd;
      if (i < NB - 1) repeat (BIT) @(posedge pclk);
    end
    if (fr[NB-1]) begin
      got = (fr >> 1) & ((16'h1 << (NB - 2)) - 16'h1);
      n_got++;
    end
  end
endmodule

/* testbench/druc_uart_asserts.sv */
// Concurrent checks on the ports of the descriptor ring UART
`timescale 1ns/1ps
`include "druc_defines.vh"
module druc_uart_asserts (
  // APB side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Line and completion pulses
  input wire rxd,
  input wire txd,
  input wire tx_event,
  input wire rx_event
);
  reg [15:0] mode;
  reg [15:0] baud;
  reg txd_d;
  reg brk_seen;
  reg [31:0] run;
  reg [1:0] off_n;
  wire wr = psel && penable && pwrite && pready;
  wire [31:0] bitc = {16'h0, baud} + 32'h1;
  wire [31:0] charc = bitc * ({28'h0, mode[11:8]} + 32'h1);
  wire rise = txd && !txd_d;
  wire fall = !txd && txd_d;
  // Shadow mode and baud, measure how long txd held its last level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MODE_RST;
      baud <= `BAUD_RST;
      txd_d <= 1'b1;
      run <= 32'h0;
      brk_seen <= 1'b0;
      off_n <= 2'h0;
    end else begin
      if (wr && paddr == 12'h000) mode <= pwdata[15:0];
      if (wr && paddr == 12'h01C) baud <= pwdata[15:0];
      txd_d <= txd;
      run <= (txd != txd_d) ? 32'h1 : run + 32'h1;
      if (rise && run > charc - bitc) brk_seen <= 1'b1;
      else if (fall) brk_seen <= 1'b0;
      off_n <= mode[`MODE_TEN] ? 2'h0 : (off_n == 2'h3 ? off_n : off_n + 2'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  tx_quiet_a: assert property (off_n == 2'h3 |-> txd)
    else $error("txd low while transmitter off");
  bit_align_a: assert property (rise |-> run % bitc == 0)
    else $error("low run not whole bits");
  break_char_a: assert property (rise && run > charc - bitc |->
    run % charc == 0)
    else $error("break not whole characters");
  idle_gap_a: assert property (fall && brk_seen |-> run >= charc)
    else $error("no idle character after break");
  tx_pulse_a: assert property (tx_event |=> !tx_event)
    else $error("tx event longer than one cycle");
  rx_pulse_a: assert property (rx_event |=> !rx_event)
    else $error("rx event longer than one cycle");
  tx_enabled_a: assert property (tx_event |-> mode[`MODE_TEN])
    else $error("tx event with transmitter off");
  cover property (tx_event);
  cover property (rx_event);
  cover property (fall && brk_seen);
endmodule
bind druc_uart druc_uart_asserts chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd,
  .tx_event, .rx_event);

/* testbench/druc_uart_tb_top.sv */
// Self-checking bench for the descriptor ring UART
`timescale 1ns/1ps
`include "druc_defines.vh"
module druc_uart_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, rxd, txd, tx_event, rx_event;
  reg [31:0] rd;
  reg er;
  integer err_total = 0;
  integer checks_done = 0;
  integer txe = 0;
  integer rxe = 0;
  integer i;
  integer k;
  always #12.5 pclk = ~pclk;
  druc_uart #(.NBD(4), .BUFW(4)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd,
    .tx_event, .rx_event);
  druc_line_partner #(.BIT(4), .NB(10)) far (.pclk, .txd, .rxd);
  // Count completion pulses
  always @(posedge pclk) begin
    if (tx_event === 1'b1) txe <= txe + 1;
    if (rx_event === 1'b1) rxe <= rxe + 1;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done++;
      if (g !== e) begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // One APB transfer: setup, access until pready, then release
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 64) begin
        @(posedge pclk);
        n++;
      end
      if (n == 64) err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input string nm, input [11:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd & m);
    end
  endtask
  task wait_chars(input integer c);
    for (k = 0; k < 4000 && far.n_got < c; k++) @(posedge pclk);
  endtask
  task t_regs;
    begin
      rdc("baud", 12'h01C, 32'hFFFF, 32'h15);
      rdc("idle limit", 12'h008, 32'hFFFF, 32'h0);
      wr(12'h018, 32'h2);
      rdc("break repeat", 12'h018, 32'hFFFF, 32'h2);
      wr(12'h00C, 32'hFFFF);
      rdc("idle countdown", 12'h00C, 32'hFFFF, 32'h0);
      apb(1'b0, 12'h500, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      $display("test regs done");
    end
  endtask
  task t_tx;
    begin
      wr(12'h01C, 32'h3);
      wr(12'h300, 32'hA5);
      wr(12'h304, 32'h3C);
      wr(12'h100, 32'h0002_B000);
      wr(12'h000, 32'h902);
      wait_chars(1);
      chk("first char", 32'hA5, {16'h0, far.got});
      wait_chars(2);
      chk("second char", 32'h3C, {16'h0, far.got});
      chk("char spacing", 32'd40, far.span);
      chk("tx events", 32'h1, txe);
      rdc("tx ready", 12'h100, 32'h8000, 32'h0);
      $display("test tx done");
    end
  endtask
  task t_cm;
    begin
      wr(12'h300, 32'h55);
      wr(12'h100, 32'h0001_A200);
      wait_chars(far.n_got + 3);
      chk("repeat char", 32'h55, {16'h0, far.got});
      rdc("cm ready", 12'h100, 32'h8000, 32'h8000);
      wr(12'h100, 32'h0);
      $display("test continuous tx done");
    end
  endtask
  task t_brk;
    begin
      wr(12'h004, `CMD_STOP_TX);
      for (k = 0; k < 2000 && far.low_max < 80; k++) @(posedge pclk);
      chk("break run", 32'd80, far.low_max);
      rdc("tx pointer", 12'h020, 32'h3, 32'h0);
      wr(12'h300, 32'h81);
      wr(12'h100, 32'h0001_A100);
      wr(12'h004, `CMD_RESTART_TX);
      wait_chars(far.n_got + 1);
      chk("preamble gap", 32'd160, far.span);
      chk("after restart", 32'h81, {16'h0, far.got});
      $display("test break tx done");
    end
  endtask
  task t_rx;
    begin
      wr(12'h008, 32'h1);
      wr(12'h200, 32'h9000);
      wr(12'h204, 32'hB000);
      wr(12'h000, 32'h903);
      for (i = 0; i < 5; i++)
        far.send({22'h0, 1'b1, 8'h11 + i[7:0], 1'b0}, 10);
      for (k = 0; k < 400 && rxe < 2; k++) @(posedge pclk);
      chk("rx events", 32'h2, rxe);
      rdc("rx desc0", 12'h200, 32'h000F_8000, 32'h0004_0000);
      rdc("rx desc1", 12'h204, 32'h000F_8100, 32'h0001_0100);
      rdc("rx word0", 12'h400, 32'hFFFF, 32'h11);
      rdc("rx word4", 12'h410, 32'hFFFF, 32'h15);
      wr(12'h200, 32'h9200);
      wr(12'h008, 32'h0);
      far.send({22'h0, 10'h2C4}, 10);
      repeat (400) @(posedge pclk);
      chk("no idle close", 32'h2, rxe);
      wr(12'h004, `CMD_CLOSE_RX);
      for (k = 0; k < 100 && rxe < 3; k++) @(posedge pclk);
      rdc("closed desc0", 12'h200, 32'h000F_8000, 32'h0001_8000);
      wr(12'h004, `CMD_CLOSE_RX);
      repeat (20) @(posedge pclk);
      chk("idle close cmd", 32'h3, rxe);
      $display("test rx done");
    end
  endtask
  task t_brk_rx;
    begin
      far.send(32'h0, 30);
      far.send(32'h1, 1);
      repeat (100) @(posedge pclk);
      rdc("break count", 12'h014, 32'hFFFF, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk("break length", 32'h1, {31'h0, rd >= 20 && rd <= 40});
      $display("test break rx done");
    end
  endtask
  task t_init;
    begin
      wr(12'h000, 32'h900);
      wr(12'h008, 32'h7);
      wr(12'h004, `CMD_INIT_RX);
      rdc("init idle limit", 12'h008, 32'hFFFF, 32'h0);
      rdc("init break count", 12'h014, 32'hFFFF, 32'h0);
      wr(12'h004, `CMD_INIT_TX);
      rdc("init repeat", 12'h018, 32'hFFFF, 32'h0);
      wr(12'h018, 32'h3);
      wr(12'h004, `CMD_INIT_BOTH);
      rdc("init both", 12'h018, 32'hFFFF, 32'h0);
      $display("test init done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // Hang guard well beyond the expected run length
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    final_report;
  end
  // Reset, then the scenarios in order
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_tx;
    t_cm;
    t_brk;
    t_rx;
    t_brk_rx;
    t_init;
    final_report;
  end
endmodule
